// ### common/batd_pkg.sv
package batd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SEL    = 8'h08;
  localparam logic [7:0] ADDR_PROF0  = 8'h0c;
  localparam logic [7:0] ADDR_PROF1  = 8'h10;
  localparam logic [7:0] ADDR_PROF2  = 8'h14;

  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_SCDMA_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_ERR_BIT   = 0;
  localparam int STAT_IUC_LSB   = 4;
  localparam int STAT_CNT_LSB   = 8;

  // ----------------------------------------------------------------
  // descriptor encoding
  // ----------------------------------------------------------------
  localparam logic [7:0] CONT_ALL      = 8'h04;
  localparam logic [7:0] CONT_ADVANCED = 8'h05;

  localparam logic [7:0] ATTR_MOD   = 8'h01;
  localparam logic [7:0] ATTR_DIFF  = 8'h02;
  localparam logic [7:0] ATTR_PLEN  = 8'h03;
  localparam logic [7:0] ATTR_POFF  = 8'h04;
  localparam logic [7:0] ATTR_FEC_T = 8'h05;
  localparam logic [7:0] ATTR_FEC_K = 8'h06;
  localparam logic [7:0] ATTR_SEED  = 8'h07;
  localparam logic [7:0] ATTR_MAXB  = 8'h08;
  localparam logic [7:0] ATTR_GUARD = 8'h09;
  localparam logic [7:0] ATTR_LCW   = 8'h0a;
  localparam logic [7:0] ATTR_SCR   = 8'h0b;

  localparam logic [15:0] SW_ON       = 16'h0001;
  localparam logic [15:0] SW_OFF      = 16'h0002;
  localparam logic [15:0] MOD_MIN     = 16'h0001;
  localparam logic [15:0] MOD_MAX_4   = 16'h0002;
  localparam logic [15:0] MOD_MAX_5   = 16'h0005;
  localparam logic [15:0] MOD_MAX_SC  = 16'h0006;
  localparam logic [15:0] PLEN_MAX_4  = 16'h0400;
  localparam logic [15:0] PLEN_MAX_5  = 16'h0600;
  localparam logic [15:0] FEC_T_MAX_4 = 16'h000a;
  localparam logic [15:0] FEC_T_MAX_5 = 16'h0010;
  localparam logic [15:0] FEC_K_MIN   = 16'h0010;
  localparam logic [15:0] FEC_K_MAX   = 16'h00fd;
  localparam logic [15:0] VAL_ZERO    = 16'h0000;
  localparam logic [15:0] VAL_ANY     = 16'hffff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CTYPE, ST_DLEN, ST_IUC, ST_ATYPE, ST_ALEN, ST_AVAL, ST_SKIP, ST_COMMIT
  } batd_state_t;

  typedef struct packed {
    logic [2:0]  modulation;
    logic        diff_on;
    logic [15:0] pre_len;
    logic [15:0] pre_off;
    logic [4:0]  fec_t;
    logic [7:0]  fec_k;
    logic [14:0] seed;
    logic [7:0]  max_burst;
    logic        max_present;
    logic [7:0]  guard;
    logic        lcw_short;
    logic        scr_on;
    logic        advanced;
    logic        err;
  } batd_profile_t;

  localparam batd_profile_t PROFILE_DEFAULT = '{
    modulation: 3'h1, diff_on: 1'b0, pre_len: 16'h0000, pre_off: 16'h0000,
    fec_t: 5'h00, fec_k: 8'h00, seed: 15'h0000, max_burst: 8'h00,
    max_present: 1'b0, guard: 8'h00, lcw_short: 1'b0, scr_on: 1'b0,
    advanced: 1'b0, err: 1'b0};

endpackage : batd_pkg

// ### verilog/batd_range_chk.sv
`timescale 1ns/1ps
module batd_range_chk (
  input  wire logic [15:0] value,
  input  wire logic [15:0] lo,
  input  wire logic [15:0] hi,
  output logic             ok
);
  assign ok = (value >= lo) && (value <= hi);
endmodule : batd_range_chk

// ### verilog/batd_prof_mem.sv
`timescale 1ns/1ps
module batd_prof_mem #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         we,
  input  wire logic [3:0]   waddr,
  input  wire logic [W-1:0] wdata,
  input  wire logic [3:0]   raddr,
  output logic      [W-1:0] rdata
);
  logic [W-1:0] mem [16];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= '0;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data always registered; a write shows one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : batd_prof_mem

// ### verilog/batd_decoder.sv
// Function
// - attributes are accepted in any order inside a descriptor
// - type 1 selects modulation codes 1 to 6; code 6 only on S-CDMA
// - modulation above 2 inside a type 4 container is flagged invalid
// - type 2 differential encoding: 1 on, 2 off
// - type 3 preamble length: at most 1536 in type 5, 1024 in type 4
// - type 4 preamble offset n starts preamble at superstring bit n+1
// - first selected preamble bit is the first mapper bit, I1 of symbol one
// - type 5 FEC T: 0 to 16 in type 5, 0 to 10 in type 4
// - T zero means no FEC, otherwise 2T parity bytes per codeword
// - type 6 k ranges 16 to 253, ignored when T is zero
// - type 7 seed is 15 bits left aligned; ignored with scrambler off
// - type 8 mini-slot limit; absent means no limit from this descriptor
// - type 9 guard time in modulation intervals after each burst
// - type 10 last codeword: 1 fixed, 2 shortened
// - IUC is the low four bits; upper four must be zero
// - container 4 is for all modems, container 5 for advanced ones
// - descriptor length counts the IUC byte and every attribute byte
`timescale 1ns/1ps
module batd_decoder (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  output logic             in_ready,
  output logic             desc_done
);

  // ----------------------------------------------------------------
  // registers and declarations
  // ----------------------------------------------------------------
  logic [1:0]                   ctrl;
  logic                         stat_err;
  logic [3:0]                   last_iuc;
  logic [7:0]                   desc_cnt;
  logic [3:0]                   sel_iuc;
  batd_pkg::batd_state_t        state;
  batd_pkg::batd_profile_t      work;
  batd_pkg::batd_profile_t      rd_prof;
  logic [3:0]                   iuc;
  logic [7:0]                   rem;
  logic [7:0]                   atype;
  logic [7:0]                   alen;
  logic [7:0]                   aidx;
  logic [15:0]                  acc;
  logic                         known_cont;
  logic                         take;
  logic                         last_byte;
  logic [15:0]                  next_acc;
  logic                         apply_now;
  logic                         known_attr;
  logic [7:0]                   exp_len;
  logic [15:0]                  lo;
  logic [15:0]                  hi;
  logic                         val_ok;
  logic                         k_ok;
  logic                         k_present;
  logic                         len_bad;
  logic                         trunc_err;
  logic                         iuc_err;
  logic                         commit_err;
  logic                         wr_en;
  logic                         rd_en;
  logic                         mapped;

  assign take      = in_valid && in_ready;
  assign in_ready  = ctrl[batd_pkg::CTRL_EN_BIT] && (state != batd_pkg::ST_COMMIT);
  assign last_byte = (rem == 8'h01);
  assign next_acc  = {acc[7:0], in_data};

  // ----------------------------------------------------------------
  // descriptor walker
  // ----------------------------------------------------------------
  // the length byte counts the IUC and all attribute bytes, so rem runs to the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= batd_pkg::ST_CTYPE;
      rem        <= 8'h00;
      atype      <= 8'h00;
      alen       <= 8'h00;
      aidx       <= 8'h00;
      acc        <= 16'h0000;
      known_cont <= 1'b0;
      iuc        <= 4'h0;
    end else if (state == batd_pkg::ST_COMMIT) begin
      state <= batd_pkg::ST_CTYPE;
    end else if (take) begin
      case (state)
        batd_pkg::ST_CTYPE: begin
          known_cont <= (in_data == batd_pkg::CONT_ALL) ||
                        (in_data == batd_pkg::CONT_ADVANCED);
          state      <= batd_pkg::ST_DLEN;
        end
        batd_pkg::ST_DLEN: begin
          rem <= in_data;
          if (in_data == 8'h00) begin
            state <= known_cont ? batd_pkg::ST_COMMIT : batd_pkg::ST_CTYPE;
          end else begin
            state <= known_cont ? batd_pkg::ST_IUC : batd_pkg::ST_SKIP;
          end
        end
        batd_pkg::ST_SKIP: begin
          rem   <= rem - 8'h01;
          state <= last_byte ? batd_pkg::ST_CTYPE : batd_pkg::ST_SKIP;
        end
        batd_pkg::ST_IUC: begin
          iuc   <= in_data[3:0];
          rem   <= rem - 8'h01;
          state <= last_byte ? batd_pkg::ST_COMMIT : batd_pkg::ST_ATYPE;
        end
        batd_pkg::ST_ATYPE: begin
          atype <= in_data;
          rem   <= rem - 8'h01;
          state <= last_byte ? batd_pkg::ST_COMMIT : batd_pkg::ST_ALEN;
        end
        batd_pkg::ST_ALEN: begin
          alen <= in_data;
          aidx <= 8'h00;
          acc  <= 16'h0000;
          rem  <= rem - 8'h01;
          if (last_byte) begin
            state <= batd_pkg::ST_COMMIT;
          end else begin
            state <= (in_data == 8'h00) ? batd_pkg::ST_ATYPE : batd_pkg::ST_AVAL;
          end
        end
        batd_pkg::ST_AVAL: begin
          acc  <= next_acc;
          aidx <= aidx + 8'h01;
          rem  <= rem - 8'h01;
          if (last_byte) begin
            state <= batd_pkg::ST_COMMIT;
          end else if (aidx == alen - 8'h01) begin
            state <= batd_pkg::ST_ATYPE;
          end
        end
        default: state <= batd_pkg::ST_CTYPE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // attribute checks
  // ----------------------------------------------------------------
  assign apply_now  = take && (state == batd_pkg::ST_AVAL) && (aidx == alen - 8'h01);
  assign known_attr = (atype >= batd_pkg::ATTR_MOD) && (atype <= batd_pkg::ATTR_SCR);
  assign exp_len    = ((atype == batd_pkg::ATTR_PLEN) || (atype == batd_pkg::ATTR_POFF) ||
                       (atype == batd_pkg::ATTR_SEED)) ? 8'h02 : 8'h01;
  assign len_bad    = take && (((state == batd_pkg::ST_ALEN) && known_attr &&
                       (in_data != exp_len)) ||
                       ((state == batd_pkg::ST_AVAL) && known_attr && (aidx >= exp_len)));
  // an attribute or header cut short by the descriptor end is an error
  assign trunc_err  = take && last_byte && (((state == batd_pkg::ST_ATYPE) ||
                       (state == batd_pkg::ST_ALEN) && (in_data != 8'h00)) ||
                       ((state == batd_pkg::ST_AVAL) && (aidx != alen - 8'h01)));
  assign iuc_err    = take && (state == batd_pkg::ST_IUC) && (in_data[7:4] != 4'h0);

  // limits depend on container; 128-QAM only when the channel is S-CDMA
  always_comb begin
    lo = batd_pkg::VAL_ZERO;
    hi = batd_pkg::VAL_ANY;
    case (atype)
      batd_pkg::ATTR_MOD: begin
        lo = batd_pkg::MOD_MIN;
        if (!work.advanced) begin
          hi = batd_pkg::MOD_MAX_4;
        end else if (ctrl[batd_pkg::CTRL_SCDMA_BIT]) begin
          hi = batd_pkg::MOD_MAX_SC;
        end else begin
          hi = batd_pkg::MOD_MAX_5;
        end
      end
      batd_pkg::ATTR_DIFF, batd_pkg::ATTR_LCW, batd_pkg::ATTR_SCR: begin
        lo = batd_pkg::SW_ON;
        hi = batd_pkg::SW_OFF;
      end
      batd_pkg::ATTR_PLEN: begin
        hi = work.advanced ? batd_pkg::PLEN_MAX_5 : batd_pkg::PLEN_MAX_4;
      end
      batd_pkg::ATTR_FEC_T: begin
        hi = work.advanced ? batd_pkg::FEC_T_MAX_5 : batd_pkg::FEC_T_MAX_4;
      end
      default: begin
        lo = batd_pkg::VAL_ZERO;
        hi = batd_pkg::VAL_ANY;
      end
    endcase
  end

  batd_range_chk u_val_chk (
    .value (next_acc),
    .lo    (lo),
    .hi    (hi),
    .ok    (val_ok)
  );

  batd_range_chk u_k_chk (
    .value ({8'h00, work.fec_k}),
    .lo    (batd_pkg::FEC_K_MIN),
    .hi    (batd_pkg::FEC_K_MAX),
    .ok    (k_ok)
  );

  // k only matters with FEC on
  assign commit_err = work.err || ((work.fec_t != 5'h00) && k_present && !k_ok);

  // ----------------------------------------------------------------
  // working profile
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work      <= batd_pkg::PROFILE_DEFAULT;
      k_present <= 1'b0;
    end else if (state == batd_pkg::ST_COMMIT) begin
      work      <= batd_pkg::PROFILE_DEFAULT;
      k_present <= 1'b0;
    end else begin
      if (take && (state == batd_pkg::ST_CTYPE)) begin
        work.advanced <= (in_data == batd_pkg::CONT_ADVANCED);
      end
      if (apply_now && known_attr && !len_bad) begin
        case (atype)
          batd_pkg::ATTR_MOD:   work.modulation <= next_acc[2:0];
          batd_pkg::ATTR_DIFF:  work.diff_on <= (next_acc == batd_pkg::SW_ON);
          batd_pkg::ATTR_PLEN:  work.pre_len <= next_acc;
          batd_pkg::ATTR_POFF:  work.pre_off <= next_acc;
          batd_pkg::ATTR_FEC_T: work.fec_t <= next_acc[4:0];
          batd_pkg::ATTR_FEC_K: begin
            work.fec_k <= next_acc[7:0];
            k_present  <= 1'b1;
          end
          batd_pkg::ATTR_SEED:  work.seed <= next_acc[15:1];
          batd_pkg::ATTR_MAXB:  begin
            work.max_burst   <= next_acc[7:0];
            work.max_present <= 1'b1;
          end
          batd_pkg::ATTR_GUARD: work.guard <= next_acc[7:0];
          batd_pkg::ATTR_LCW:   work.lcw_short <= (next_acc == batd_pkg::SW_OFF);
          batd_pkg::ATTR_SCR:   work.scr_on <= (next_acc == batd_pkg::SW_ON);
          default:              work.err <= work.err;
        endcase
      end
      // unknown attribute types reach this term only through trunc_err, so complete ones skip silently
      if ((apply_now && known_attr && !val_ok) || len_bad || trunc_err || iuc_err) begin
        work.err <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // profile table and status
  // ----------------------------------------------------------------
  batd_prof_mem #(
    .W ($bits(batd_pkg::batd_profile_t))
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (state == batd_pkg::ST_COMMIT),
    .waddr   (iuc),
    .wdata   ({work[$bits(batd_pkg::batd_profile_t)-1:1], commit_err}),
    .raddr   (sel_iuc),
    .rdata   (rd_prof)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc_done <= 1'b0;
      last_iuc  <= 4'h0;
      desc_cnt  <= 8'h00;
    end else begin
      desc_done <= (state == batd_pkg::ST_COMMIT);
      if (state == batd_pkg::ST_COMMIT) begin
        last_iuc <= iuc;
        desc_cnt <= desc_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign mapped  = (paddr == batd_pkg::ADDR_CTRL) || (paddr == batd_pkg::ADDR_STATUS) ||
                   (paddr == batd_pkg::ADDR_SEL) || (paddr == batd_pkg::ADDR_PROF0) ||
                   (paddr == batd_pkg::ADDR_PROF1) || (paddr == batd_pkg::ADDR_PROF2);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en   = psel && penable && pwrite && mapped;
  assign rd_en   = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= batd_pkg::CTRL_RESET;
      sel_iuc <= 4'h0;
    end else if (wr_en) begin
      if (paddr == batd_pkg::ADDR_CTRL) begin
        ctrl <= pwdata[1:0];
      end
      if (paddr == batd_pkg::ADDR_SEL) begin
        sel_iuc <= pwdata[3:0];
      end
    end
  end

  // write one clears; a descriptor error in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_err <= 1'b0;
    end else if ((state == batd_pkg::ST_COMMIT) && commit_err) begin
      stat_err <= 1'b1;
    end else if (wr_en && (paddr == batd_pkg::ADDR_STATUS) &&
                 pwdata[batd_pkg::STAT_ERR_BIT]) begin
      stat_err <= 1'b0;
    end
  end

  // read data latched in the setup cycle, stable through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        batd_pkg::ADDR_CTRL:   prdata <= {30'h00000000, ctrl};
        batd_pkg::ADDR_STATUS: prdata <= {16'h0000, desc_cnt, last_iuc, 3'h0, stat_err};
        batd_pkg::ADDR_SEL:    prdata <= {28'h0000000, sel_iuc};
        batd_pkg::ADDR_PROF0:  prdata <= {4'h0, rd_prof.err, rd_prof.advanced,
                                          rd_prof.max_present, rd_prof.scr_on,
                                          rd_prof.lcw_short,
                                          (rd_prof.fec_t != 5'h00),
                                          rd_prof.fec_t, 1'b0,
                                          rd_prof.fec_k, 3'h0, rd_prof.fec_t[0],
                                          rd_prof.diff_on, rd_prof.modulation};
        // offset n is the zero-based index of the first bit fed to the mapper
        batd_pkg::ADDR_PROF1:  prdata <= {rd_prof.pre_off, rd_prof.pre_len};
        batd_pkg::ADDR_PROF2:  prdata <= {rd_prof.guard, rd_prof.max_burst, 1'b0,
                                          rd_prof.scr_on ? rd_prof.seed : 15'h0000};
        default:               prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_commit;
    state == batd_pkg::ST_COMMIT;
  endsequence

  sequence s_done_back;
    desc_done ##1 !desc_done;
  endsequence

  a_commit_done_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_commit |=> s_done_back) else $error("commit not followed by one-cycle done");

  a_iuc_upper_err: assert property (@(posedge pclk) disable iff (!presetn)
    iuc_err |=> work.err) else $error("nonzero IUC upper bits not flagged");

  a_mod_cont4_cap: assert property (@(posedge pclk) disable iff (!presetn)
    apply_now && (atype == batd_pkg::ATTR_MOD) && !work.advanced &&
    (next_acc > batd_pkg::MOD_MAX_4) |=> work.err)
    else $error("type 4 modulation above 2 not flagged");

  a_plen_limit: assert property (@(posedge pclk) disable iff (!presetn)
    apply_now && (atype == batd_pkg::ATTR_PLEN) && !work.advanced &&
    (next_acc > batd_pkg::PLEN_MAX_4) |=> work.err)
    else $error("type 4 preamble length over limit not flagged");

  a_fec_t_range: assert property (@(posedge pclk) disable iff (!presetn)
    apply_now && (atype == batd_pkg::ATTR_FEC_T) &&
    (next_acc > (work.advanced ? batd_pkg::FEC_T_MAX_5 : batd_pkg::FEC_T_MAX_4)) |=> work.err)
    else $error("FEC T over limit not flagged");

  a_seed_align: assert property (@(posedge pclk) disable iff (!presetn)
    apply_now && (atype == batd_pkg::ATTR_SEED) && (alen == 8'h02) |=>
    (work.seed == $past(next_acc[15:1]))) else $error("seed not left aligned");

  a_diff_switch: assert property (@(posedge pclk) disable iff (!presetn)
    apply_now && (atype == batd_pkg::ATTR_DIFF) && (alen == 8'h01) &&
    (next_acc == batd_pkg::SW_ON) |=> work.diff_on) else $error("diff encoding not on");

  a_maxb_present: assert property (@(posedge pclk) disable iff (!presetn)
    apply_now && (atype == batd_pkg::ATTR_MAXB) && (alen == 8'h01) |=>
    work.max_present) else $error("max burst not marked");

  a_unknown_skip: assert property (@(posedge pclk) disable iff (!presetn)
    take && (state == batd_pkg::ST_AVAL) && !known_attr && !work.err && !trunc_err
    |=> !work.err) else $error("unknown attribute raised an error");

endmodule : batd_decoder

// ### verification/batd_cmts_model.sv
`timescale 1ns/1ps
module batd_cmts_model (
  input  wire logic       pclk,
  input  wire logic       in_ready,
  output logic            in_valid,
  output logic      [7:0] in_data
);
  logic [7:0] q[$];
  logic       slow  = 1'b0;
  logic       pause = 1'b0;
  initial in_valid = 1'b0;
  initial in_data = 8'h00;
  // the bench queues whole descriptors, one per code the map will use
  always @(posedge pclk) begin
    pause <= ~pause;
    if (!in_valid || in_ready) begin
      if (q.size() > 0 && !(slow && pause)) begin
        in_valid <= 1'b1;
        in_data  <= q.pop_front();
      end else begin
        in_valid <= 1'b0;
        in_data  <= ~in_data; // an idle line toggles, so it shows the last byte inverted on alternate idle cycles
      end
    end
  end
endmodule : batd_cmts_model

// ### verification/burst_attribute_tlv_decoder_tb_top.sv
`timescale 1ns/1ps
module burst_attribute_tlv_decoder_tb_top;
  typedef struct packed {
    logic [7:0]  iuc;
    logic [7:0]  ct;
    logic        sc;
    logic [7:0]  at;
    logic [15:0] v;
    logic        e;
  } batd_case_t;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, r;
  logic        pready, pslverr, in_valid, in_ready, desc_done, e;
  logic [7:0]  in_data;
  logic [31:0] p [3];
  int          num_errors   = 0;
  int          total_checks = 0;
  batd_case_t  tc [11] = '{
    '{8'h03, 8'h04, 1'b0, 8'h01, 16'h0003, 1'b1}, '{8'h04, 8'h04, 1'b0, 8'h01, 16'h0002, 1'b0},
    '{8'h05, 8'h05, 1'b0, 8'h01, 16'h0006, 1'b1}, '{8'h06, 8'h05, 1'b1, 8'h01, 16'h0006, 1'b0},
    '{8'h07, 8'h04, 1'b0, 8'h03, 16'h0401, 1'b1}, '{8'h08, 8'h04, 1'b0, 8'h03, 16'h0400, 1'b0},
    '{8'h09, 8'h05, 1'b0, 8'h03, 16'h0601, 1'b1}, '{8'h0a, 8'h04, 1'b0, 8'h05, 16'h000b, 1'b1},
    '{8'h0b, 8'h05, 1'b0, 8'h05, 16'h0010, 1'b0}, '{8'h0c, 8'h05, 1'b0, 8'h02, 16'h0003, 1'b1},
    '{8'h1e, 8'h05, 1'b0, 8'h0a, 16'h0001, 1'b1}};

  batd_decoder dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .in_valid, .in_data, .in_ready, .desc_done);
  batd_cmts_model m (.pclk, .in_ready, .in_valid, .in_data);

  initial forever #25 pclk = ~pclk;

  // ----------------------------------------------------------------
  // bus and stream tasks
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic send(input logic [7:0] ct, input logic [7:0] iuc, input logic [7:0] t[$]);
    m.q.push_back(ct);
    m.q.push_back(8'(t.size() + 1));
    m.q.push_back(iuc);
    foreach (t[i]) m.q.push_back(t[i]);
    for (int i = 0; i < 400 && desc_done !== 1'b1; i++) @(negedge pclk);
    check("desc_done", {31'h0, desc_done}, 32'h1);
  endtask : send

  task automatic prof(input logic [3:0] i);
    apb(1'b1, batd_pkg::ADDR_SEL, {28'h0, i});
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, batd_pkg::ADDR_PROF0 + 8'(4 * k), 32'h0);
      p[k] = r;
    end
  endtask : prof

  task automatic complete_run;
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, batd_pkg::ADDR_STATUS, 32'h0);
    check("status reset", r, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped", {r[31:1], e}, 32'h1);
    apb(1'b1, batd_pkg::ADDR_CTRL, 32'h1);
    m.slow = 1'b1;
    m.q = '{8'h03, 8'h02, 8'haa, 8'hbb}; // a foreign container is skipped whole
    // preamble fields are whole 16-qam symbols
    send(8'h04, 8'h01, '{8'h20, 8'h02, 8'haa, 8'hbb, 8'h05, 8'h01, 8'h08, 8'h06, 8'h01, 8'h64,
      8'h01, 8'h01, 8'h02, 8'h02, 8'h01, 8'h01, 8'h03, 8'h02, 8'h00, 8'h40, 8'h04, 8'h02,
      8'h00, 8'h64, 8'h07, 8'h02, 8'hab, 8'hcd, 8'h08, 8'h01, 8'h0a, 8'h09, 8'h01, 8'h05,
      8'h0a, 8'h01, 8'h02, 8'h0b, 8'h01, 8'h01});
    prof(4'h1);
    check("prof0 a", p[0], 32'h03d0640a);
    check("prof1 a", p[1], 32'h00640040);
    check("prof2 a", p[2], 32'h050a55e6);
    m.slow = 1'b0;
    send(8'h05, 8'h02, '{8'h05, 8'h01, 8'h00, 8'h06, 8'h01, 8'h05, 8'h0b, 8'h01, 8'h02,
      8'h07, 8'h02, 8'h12, 8'h34});
    prof(4'h2);
    check("prof0 b", p[0] & 32'h0fff00ff, 32'h04000001);
    check("prof2 b", p[2], 32'h0);
    foreach (tc[i]) begin
      apb(1'b1, batd_pkg::ADDR_CTRL, {30'h0, tc[i].sc, 1'b1});
      // every descriptor carries a non-zero burst limit and a one-interval guard
      if (tc[i].at inside {8'h03, 8'h07})
        send(tc[i].ct, tc[i].iuc, '{8'h08, 8'h01, 8'h01, 8'h09, 8'h01, 8'h01,
          tc[i].at, 8'h02, tc[i].v[15:8], tc[i].v[7:0]});
      else
        send(tc[i].ct, tc[i].iuc, '{8'h08, 8'h01, 8'h01, 8'h09, 8'h01, 8'h01,
          tc[i].at, 8'h01, tc[i].v[7:0]});
      prof(tc[i].iuc[3:0]);
      check("prof0 err", {31'h0, p[0][27]}, {31'h0, tc[i].e});
      check("prof0 maxb", {31'h0, p[0][25]}, 32'h1);
      check("prof2 guard", {24'h0, p[2][31:24]}, 32'h1);
    end
    apb(1'b0, batd_pkg::ADDR_STATUS, 32'h0);
    check("status", r, 32'h00000de1);
    apb(1'b1, batd_pkg::ADDR_STATUS, 32'h1);
    apb(1'b0, batd_pkg::ADDR_STATUS, 32'h0);
    check("status clear", r, 32'h00000de0);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    complete_run();
  end
endmodule : burst_attribute_tlv_decoder_tb_top
